// [core/bus_fault_status_flags.sv]
// Purpose: bus fault status flags, address captures and deferred fault pending
// Assumes: fault events arrive from core logic on clk_in, no synchronisers needed
// Notes:   registers are reached by a plain strobe port, read data one cycle later
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module bus_fault_status_flags
   import fault_flags_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   // register port
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic [DATA_W-1:0]      rdata_out,
   // fault events
   input  wire data_fault_t       data_in,
   input  wire fetch_evt_t        fetch_in,
   input  wire logic [PRIO_W-1:0] exec_prio_in,
   input  wire logic              bf_handler_entry_in,
   // processor side results
   output logic                   bf_take_out,
   output logic                   bf_pending_out,
   output logic [DATA_W-1:0]      stacked_pc_out,
   output logic                   irq_out
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] ofs
   );
      hit = (a == ofs);
   endfunction

   // flag vector order differs from bit order, so both directions go through one place
   function automatic logic [DATA_W-1:0] pack_flags(
      input logic [NFLAG-1:0] f
   );
      logic [DATA_W-1:0] w;
      w = RST_WORD;
      w[BIT_DEFERRED] = f[IX_DEFERRED];
      w[BIT_EXACT]    = f[IX_EXACT];
      w[BIT_IFETCH]   = f[IX_IFETCH];
      w[BIT_MMVALID]  = f[IX_MMVALID];
      pack_flags = w;
   endfunction

   function automatic logic [NFLAG-1:0] unpack_flags(
      input logic [DATA_W-1:0] w
   );
      logic [NFLAG-1:0] f;
      f = RST_FLAGS;
      f[IX_DEFERRED] = w[BIT_DEFERRED];
      f[IX_EXACT]    = w[BIT_EXACT];
      f[IX_IFETCH]   = w[BIT_IFETCH];
      f[IX_MMVALID]  = w[BIT_MMVALID];
      unpack_flags = f;
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   typedef enum logic [0:0] {
      PEND_IDLE = 1'b0,
      PEND_WAIT = 1'b1
   } pend_state_t;

   logic              wr_stat;
   logic              wr_prio;
   logic              wr_mask;
   logic              rd_int;
   logic [NFLAG-1:0]  clr_vec;
   logic [NFLAG-1:0]  set_vec;
   logic [NFLAG-1:0]  flags;
   logic              ifetch_set;
   logic              exact_set;
   logic              deferred_set;
   logic              mm_set;
   logic              addr_wr_ok;
   logic [DATA_W-1:0] bus_fault_address_reg_r;
   logic [DATA_W-1:0] memfault_capture_address_r;
   logic [DATA_W-1:0] stacked_pc_r;
   logic [PRIO_W-1:0] bf_prio_r;
   pend_state_t       pend_r;
   pend_state_t       pend_nxt;
   logic              take_ok;
   logic [NFLAG-1:0]  int_stat_r;
   logic [NFLAG-1:0]  int_stat_nxt;
   logic [NFLAG-1:0]  int_mask_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   // read-only offsets have no write decode, so writes there fall away
   assign wr_stat = wr_in & hit(addr_in, OFS_FAULT_STAT);
   assign wr_prio = wr_in & hit(addr_in, OFS_BF_PRIO);
   assign wr_mask = wr_in & hit(addr_in, OFS_INT_MASK);
   assign rd_int  = rd_in & hit(addr_in, OFS_INT_STAT);

   always_comb begin
      clr_vec = RST_FLAGS;
      if (wr_stat) begin
         clr_vec = unpack_flags(wdata_in);
      end
   end

   // ----------------------------------------
   // event qualification
   // ----------------------------------------
   // events come from core logic on this clock, so they need no synchronisers
   assign deferred_set = data_in.deferred;
   assign exact_set    = data_in.exact;
   assign mm_set       = data_in.mm_fault;

   // the tracker forgets marks on a flush, so only issued faults reach the flag
   prefetch_fault_track u_fetch (
      .clk_in          (clk_in),
      .rst_n_in        (rst_n_in),
      .evt_in          (fetch_in),
      .issue_fault_out (ifetch_set)
   );

   always_comb begin
      set_vec = RST_FLAGS;
      set_vec[IX_DEFERRED] = deferred_set;
      set_vec[IX_EXACT]    = exact_set;
      set_vec[IX_IFETCH]   = ifetch_set;
      set_vec[IX_MMVALID]  = mm_set;
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   // flags set independently
   w1c_flag u_flag_deferred (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .set_in   (set_vec[IX_DEFERRED]),
      .clr_in   (clr_vec[IX_DEFERRED]),
      .flag_out (flags[IX_DEFERRED])
   );

   w1c_flag u_flag_exact (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .set_in   (set_vec[IX_EXACT]),
      .clr_in   (clr_vec[IX_EXACT]),
      .flag_out (flags[IX_EXACT])
   );

   w1c_flag u_flag_ifetch (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .set_in   (set_vec[IX_IFETCH]),
      .clr_in   (clr_vec[IX_IFETCH]),
      .flag_out (flags[IX_IFETCH])
   );

   w1c_flag u_flag_mmvalid (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .set_in   (set_vec[IX_MMVALID]),
      .clr_in   (clr_vec[IX_MMVALID]),
      .flag_out (flags[IX_MMVALID])
   );

   // ----------------------------------------
   // address captures
   // ----------------------------------------
   // no write on deferred or fetch
   assign addr_wr_ok = exact_set & ~deferred_set & ~ifetch_set;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_fault_address_reg_r <= RST_WORD;
      end else if (addr_wr_ok) begin
         bus_fault_address_reg_r <= data_in.exact_addr;
      end
   end

   // the pc follows every exact error, the address capture only a lone one
   // stack faulting pc
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stacked_pc_r <= RST_WORD;
      end else if (exact_set) begin
         stacked_pc_r <= data_in.exact_pc;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         memfault_capture_address_r <= RST_WORD;
      end else if (mm_set) begin
         memfault_capture_address_r <= data_in.mm_addr;
      end
   end

   // ----------------------------------------
   // deferred fault pending
   // ----------------------------------------
   // only the low byte holds the priority, the rest of the write falls away
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bf_prio_r <= RST_PRIO;
      end else if (wr_prio) begin
         bf_prio_r <= wdata_in[PRIO_W-1:0];
      end
   end

   // a lower number is more urgent, so a larger current number lets the fault in
   // wait for priority
   assign take_ok = (pend_r == PEND_WAIT) & (exec_prio_in > bf_prio_r);

   always_comb begin
      pend_nxt = pend_r;
      unique case (pend_r)
         PEND_IDLE: begin
            if (deferred_set) begin
               pend_nxt = PEND_WAIT;
            end
         end
         PEND_WAIT: begin
            // a new error in the leaving cycle keeps the fault pending
            if ((take_ok | bf_handler_entry_in) & ~deferred_set) begin
               pend_nxt = PEND_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pend_r <= PEND_IDLE;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   // one status bit per flag, in flag vector order
   // read clears, but a new event in that cycle survives
   always_comb begin
      int_stat_nxt = int_stat_r;
      if (rd_int) begin
         int_stat_nxt = RST_FLAGS;
      end
      int_stat_nxt = int_stat_nxt | set_vec;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         int_stat_r <= RST_FLAGS;
      end else begin
         int_stat_r <= int_stat_nxt;
      end
   end

   // the mask only gates the output, status still records masked events
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         int_mask_r <= RST_FLAGS;
      end else if (wr_mask) begin
         int_mask_r <= wdata_in[NFLAG-1:0];
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // data stand for one cycle only, then fall back to zero
   always_comb begin
      rdata_nxt = RST_WORD;
      if (rd_in) begin
         unique case (addr_in)
            OFS_FAULT_STAT: begin
               rdata_nxt = pack_flags(flags);
            end
            OFS_BUS_ADDR: begin
               rdata_nxt = bus_fault_address_reg_r;
            end
            OFS_MM_ADDR: begin
               rdata_nxt = memfault_capture_address_r;
            end
            OFS_BF_PRIO: begin
               rdata_nxt[PRIO_W-1:0] = bf_prio_r;
            end
            OFS_INT_STAT: begin
               rdata_nxt[NFLAG-1:0] = int_stat_r;
            end
            OFS_INT_MASK: begin
               rdata_nxt[NFLAG-1:0] = int_mask_r;
            end
            OFS_PEND_STAT: begin
               rdata_nxt[0] = (pend_r == PEND_WAIT);
            end
            // unmapped addresses read as zero
            default: begin
               rdata_nxt = RST_WORD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_r <= RST_WORD;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rdata_out      = rdata_r;
   assign stacked_pc_out = stacked_pc_r;
   assign bf_pending_out = (pend_r == PEND_WAIT);
   assign bf_take_out    = take_ok;
   // irq comes from flops only, so register port inputs cannot glitch it
   assign irq_out        = |(int_stat_r & int_mask_r);

endmodule
`default_nettype wire

// [core/fault_flags_pkg.sv]
// Purpose: constants and carrier types for the bus fault status flag block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   higher priority means a lower priority number
//
// Summary of operation
// - a deferred data error or a fetch error never writes the bus fault address register.
// - a deferred data error under a more urgent priority stays pending until allowed.
// - an exact fault before deferred handler entry leaves both flags set together.
// - an exact data error sets bit 9 and the stacked return pc is the faulting one.
// - an exact data error captures its data address into the bus fault address register, unless a deferred error or issued fetch fault shares its cycle.
// - a prefetch error sets bit 8 only when that instruction issues, never when discarded.
// - bit 7 is 1 only while the memfault capture address holds a valid address.
// - each flag resets to 0 and is cleared by software writing 1 to its bit.
// - the deferred data error flag sits at bit 10, write one to clear, reset zero.
package fault_flags_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PRIO_W = 8;
   localparam int SLOT_W = 2;
   localparam int SLOTS  = 4;
   localparam int NFLAG  = 4;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_FAULT_STAT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_BUS_ADDR   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MM_ADDR    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_BF_PRIO    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PEND_STAT  = 8'h18;

   // ----------------------------------------
   // field positions in the fault status word
   // ----------------------------------------
   localparam int BIT_DEFERRED = 10;
   localparam int BIT_EXACT    = 9;
   localparam int BIT_IFETCH   = 8;
   localparam int BIT_MMVALID  = 7;

   // flag index inside the flag vector and the interrupt words
   localparam int IX_DEFERRED = 0;
   localparam int IX_EXACT    = 1;
   localparam int IX_IFETCH   = 2;
   localparam int IX_MMVALID  = 3;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [DATA_W-1:0] RST_WORD  = 32'h0000_0000;
   localparam logic [PRIO_W-1:0] RST_PRIO  = 8'h00;
   localparam logic [NFLAG-1:0]  RST_FLAGS = 4'h0;
   localparam logic [SLOTS-1:0]  RST_SLOTS = 4'h0;

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic              deferred;
      logic              exact;
      logic [DATA_W-1:0] exact_addr;
      logic [DATA_W-1:0] exact_pc;
      logic              mm_fault;
      logic [DATA_W-1:0] mm_addr;
   } data_fault_t;

   typedef struct packed {
      logic              fetch_err;
      logic [SLOT_W-1:0] fetch_slot;
      logic              issue;
      logic [SLOT_W-1:0] issue_slot;
      logic              discard;
   } fetch_evt_t;

endpackage

// [core/w1c_flag.sv]
// Purpose: one sticky status flag, set by hardware, cleared by writing 1
// Assumes: set and clear come from logic on the same clock
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module w1c_flag (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic set_in,
   input  wire logic clr_in,
   output var  logic flag_out
);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_out <= 1'b0;
      end else if (set_in) begin
         flag_out <= 1'b1;
      end else if (clr_in) begin
         flag_out <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [core/prefetch_fault_track.sv]
// Purpose: marks prefetch slots whose fetch failed on the bus
// Assumes: slots are indexed by the fetch unit
// Notes:   a flush forgets every mark, so discarded fetches never fault
`timescale 1ns/10ps
`default_nettype none
module prefetch_fault_track
   import fault_flags_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire fetch_evt_t evt_in,
   output logic            issue_fault_out
);

   logic [SLOTS-1:0] bad_r;
   logic [SLOTS-1:0] bad_nxt;

   always_comb begin
      bad_nxt = bad_r;
      if (evt_in.issue) begin
         bad_nxt[evt_in.issue_slot] = 1'b0;
      end
      if (evt_in.fetch_err) begin
         bad_nxt[evt_in.fetch_slot] = 1'b1;
      end
      if (evt_in.discard) begin
         bad_nxt = RST_SLOTS;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bad_r <= RST_SLOTS;
      end else begin
         bad_r <= bad_nxt;
      end
   end

   assign issue_fault_out = evt_in.issue & bad_r[evt_in.issue_slot] & ~evt_in.discard;

endmodule
`default_nettype wire

// [dv/bus_fault_flags_monitor.sv]
// Purpose: port checker for the bus fault flag block
// Assumes: one clock domain, async active-low reset
// Notes:   sees only top ports, so register state is judged through reads
`timescale 1ns/10ps
`default_nettype none
module bus_fault_flags_monitor
   import fault_flags_pkg::*;
(
   input wire logic              clk_in,
   input wire logic              rst_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic              wr_in,
   input wire logic              rd_in,
   input wire logic [DATA_W-1:0] rdata_out,
   input wire data_fault_t       data_in,
   input wire fetch_evt_t        fetch_in,
   input wire logic [PRIO_W-1:0] exec_prio_in,
   input wire logic              bf_handler_entry_in,
   input wire logic              bf_take_out,
   input wire logic              bf_pending_out,
   input wire logic [DATA_W-1:0] stacked_pc_out,
   input wire logic              irq_out
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic st_rd;
   assign st_rd = rd_in && addr_in == OFS_FAULT_STAT;

   property p_pc;
      data_in.exact |=> stacked_pc_out == $past(data_in.exact_pc);
   endproperty
   property p_exact;
      data_in.exact ##1 st_rd |=> rdata_out[BIT_EXACT];
   endproperty
   property p_defer;
      data_in.deferred ##1 st_rd |=> rdata_out[BIT_DEFERRED];
   endproperty
   property p_mmv;
      data_in.mm_fault ##1 st_rd |=> rdata_out[BIT_MMVALID];
   endproperty
   // an exact error with no deferred fault and no fetch issue must land in the capture
   property p_addr;
      data_in.exact && !data_in.deferred && !fetch_in.issue
         ##1 (rd_in && addr_in == OFS_BUS_ADDR)
         |=> rdata_out == $past(data_in.exact_addr, 2);
   endproperty
   property p_pend;
      data_in.deferred |=> bf_pending_out;
   endproperty
   property p_drop;
      (bf_take_out || bf_handler_entry_in) && !data_in.deferred |=> !bf_pending_out;
   endproperty
   property p_both;
      data_in.deferred ##1 (data_in.exact && !bf_handler_entry_in && !wr_in) ##1 st_rd
         |=> rdata_out[BIT_DEFERRED:BIT_EXACT] == 2'b11;
   endproperty

   a_pc: assert property (p_pc) else $error("stacked pc not the faulting pc");
   a_exact: assert property (p_exact) else $error("exact flag not set");
   a_defer: assert property (p_defer) else $error("deferred flag not set");
   a_mmv: assert property (p_mmv) else $error("memfault valid not set");
   a_addr: assert property (p_addr) else $error("fault address not captured");
   a_pend: assert property (p_pend) else $error("deferred fault not pending");
   a_drop: assert property (p_drop) else $error("pending not dropped");
   a_both: assert property (p_both) else $error("both flags not set");

   c_take: cover property (bf_take_out);
   c_exact: cover property (data_in.exact);
   c_issue: cover property (fetch_in.issue);
endmodule

bind bus_fault_status_flags bus_fault_flags_monitor u_mon (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .data_in(data_in),
   .fetch_in(fetch_in), .exec_prio_in(exec_prio_in),
   .bf_handler_entry_in(bf_handler_entry_in), .bf_take_out(bf_take_out),
   .bf_pending_out(bf_pending_out), .stacked_pc_out(stacked_pc_out), .irq_out(irq_out)
);
`default_nettype wire

// [dv/bus_fault_status_flags_bench.sv]
// Purpose: self-checking bench for the bus fault flag block
// Assumes: one clock, strobe register port, read data one cycle later
// Notes:   directed tasks only, no randomness
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module bus_fault_status_flags_bench
   import fault_flags_pkg::*;
;
   // ----------------------------------------
   // stimulus and dut
   // ----------------------------------------
   logic              clk_in = 1'b0;
   logic              rst_n_in = 1'b0;
   logic              wr_in = 1'b0;
   logic              rd_in = 1'b0;
   logic              bf_handler_entry_in = 1'b0;
   logic [ADDR_W-1:0] addr_in = '0;
   logic [DATA_W-1:0] wdata_in = '0;
   logic [PRIO_W-1:0] exec_prio_in = '0;
   data_fault_t       data_in = '0;
   fetch_evt_t        fetch_in = '0;
   logic [DATA_W-1:0] rdata_out;
   logic [DATA_W-1:0] stacked_pc_out;
   logic              bf_take_out;
   logic              bf_pending_out;
   logic              irq_out;
   int                num_errors = 0;
   int                cmp_count = 0;

   always #4 clk_in = ~clk_in;

   bus_fault_status_flags u_dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .data_in(data_in),
      .fetch_in(fetch_in), .exec_prio_in(exec_prio_in),
      .bf_handler_entry_in(bf_handler_entry_in), .bf_take_out(bf_take_out),
      .bf_pending_out(bf_pending_out), .stacked_pc_out(stacked_pc_out), .irq_out(irq_out)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   function automatic data_fault_t mk(logic df, logic ex, logic mm, logic [DATA_W-1:0] ad);
      data_fault_t d;
      d = '0;
      d.deferred = df;
      d.exact = ex;
      d.exact_addr = ad;
      d.exact_pc = ~ad;
      d.mm_fault = mm;
      d.mm_addr = ad;
      return d;
   endfunction

   function automatic fetch_evt_t fk(logic e, logic [1:0] s1, logic i, logic [1:0] s2, logic c);
      return {e, s1, i, s2, c};
   endfunction

   task automatic w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 `CHK(rdata_out, e)
   endtask

   task automatic ev(input data_fault_t d, input fetch_evt_t f);
      @(posedge clk_in);
      data_in <= d;
      fetch_in <= f;
      @(posedge clk_in);
      data_in <= '0;
      fetch_in <= '0;
   endtask

   // event, then a read in the very next cycle
   task automatic evr(input data_fault_t d, input fetch_evt_t f, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] e);
      @(posedge clk_in);
      data_in <= d;
      fetch_in <= f;
      @(posedge clk_in);
      data_in <= '0;
      fetch_in <= '0;
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 `CHK(rdata_out, e)
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_rst;
      rc(OFS_FAULT_STAT, 32'h0000_0000);
      w(OFS_BUS_ADDR, 32'hFFFF_FFFF);
      rc(OFS_BUS_ADDR, 32'h0000_0000);
      rc(8'h40, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_exact;
      evr(mk(1'b0, 1'b1, 1'b0, 32'h2000_0010), '0, OFS_BUS_ADDR, 32'h2000_0010);
      `CHK(stacked_pc_out, ~32'h2000_0010)
      rc(OFS_FAULT_STAT, 32'h0000_0200);
      w(OFS_FAULT_STAT, 32'h0000_0000);
      rc(OFS_FAULT_STAT, 32'h0000_0200);
      w(OFS_FAULT_STAT, 32'h0000_0200);
      rc(OFS_FAULT_STAT, 32'h0000_0000);
      $display("test exact done");
   endtask

   task automatic t_defer;
      w(OFS_BF_PRIO, 32'h0000_0010);
      exec_prio_in <= 8'h05;
      rc(OFS_BF_PRIO, 32'h0000_0010);
      evr(mk(1'b1, 1'b0, 1'b0, 32'h3000_0000), '0, OFS_FAULT_STAT, 32'h0000_0400);
      `CHK({bf_pending_out, bf_take_out}, 2'b10)
      rc(OFS_PEND_STAT, 32'h0000_0001);
      // deferred and exact in one cycle must leave the address capture alone
      evr(mk(1'b1, 1'b1, 1'b0, 32'h3000_0004), '0, OFS_BUS_ADDR, 32'h2000_0010);
      w(OFS_FAULT_STAT, 32'h0000_0600);
      @(posedge clk_in);
      data_in <= mk(1'b1, 1'b0, 1'b0, 32'h3000_0008);
      evr(mk(1'b0, 1'b1, 1'b0, 32'h2000_0020), '0, OFS_FAULT_STAT, 32'h0000_0600);
      @(posedge clk_in);
      exec_prio_in <= 8'h20;
      #1 `CHK(bf_take_out, 1'b1)
      @(posedge clk_in);
      #1 `CHK(bf_pending_out, 1'b0)
      @(posedge clk_in);
      exec_prio_in <= 8'h05;
      ev(mk(1'b1, 1'b0, 1'b0, 32'h3000_000C), '0);
      bf_handler_entry_in <= 1'b1;
      #1 `CHK(bf_pending_out, 1'b1)
      @(posedge clk_in);
      bf_handler_entry_in <= 1'b0;
      #1 `CHK(bf_pending_out, 1'b0)
      w(OFS_FAULT_STAT, 32'h0000_0600);
      $display("test deferred done");
   endtask

   // a discarded prefetch must not leave a mark behind
   task automatic t_fetch;
      rc(OFS_INT_STAT, 32'h0000_0003);
      w(OFS_INT_MASK, 32'h0000_0004);
      rc(OFS_INT_MASK, 32'h0000_0004);
      ev('0, fk(1'b1, 2'd1, 1'b0, 2'd0, 1'b0));
      ev('0, fk(1'b0, 2'd0, 1'b0, 2'd0, 1'b1));
      ev('0, fk(1'b0, 2'd0, 1'b1, 2'd1, 1'b0));
      rc(OFS_FAULT_STAT, 32'h0000_0000);
      ev('0, fk(1'b1, 2'd2, 1'b0, 2'd0, 1'b0));
      // an issuing fetch fault beside an exact error keeps the address capture
      ev(mk(1'b0, 1'b1, 1'b0, 32'h6000_0000), fk(1'b0, 2'd0, 1'b1, 2'd2, 1'b0));
      #1 `CHK(irq_out, 1'b1)
      rc(OFS_FAULT_STAT, 32'h0000_0300);
      rc(OFS_INT_STAT, 32'h0000_0006);
      `CHK(irq_out, 1'b0)
      rc(OFS_BUS_ADDR, 32'h2000_0020);
      w(OFS_FAULT_STAT, 32'h0000_0300);
      $display("test fetch done");
   endtask

   task automatic t_mm;
      evr(mk(1'b0, 1'b0, 1'b1, 32'h4000_0008), '0, OFS_FAULT_STAT, 32'h0000_0080);
      rc(OFS_MM_ADDR, 32'h4000_0008);
      `CHK(irq_out, 1'b0)
      w(OFS_FAULT_STAT, 32'h0000_0080);
      rc(OFS_FAULT_STAT, 32'h0000_0000);
      $display("test memfault done");
   endtask

   // set and clear land on one edge: the set must survive
   task automatic t_race;
      @(posedge clk_in);
      data_in <= mk(1'b0, 1'b1, 1'b0, 32'h5000_0000);
      wr_in <= 1'b1;
      addr_in <= OFS_FAULT_STAT;
      wdata_in <= 32'h0000_0200;
      @(posedge clk_in);
      data_in <= '0;
      wr_in <= 1'b0;
      rc(OFS_FAULT_STAT, 32'h0000_0200);
      $display("test race done");
   endtask

   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_rst;
      t_exact;
      t_defer;
      t_fetch;
      t_mm;
      t_race;
      results;
   end

   initial begin
      #100000;
      num_errors++;
      results;
   end
endmodule
`default_nettype wire
